// *** include/dcml_consts.svh ***
// constants for the data cache maintenance and lockdown block
`ifndef DCML_CONSTS_SVH
`define DCML_CONSTS_SVH
`define DCML_LOCK_LOAD_BIT 31
`define DCML_LOCK_IDX_HI 1
`define DCML_LOCK_IDX_LO 0
`define DCML_LOCK_RESET 32'h0000_0000
`define DCML_SEG_HI 31
`define DCML_SEG_LO 30
`define DCML_LINE_LO 5
`define DCML_SET_LINE_BYTES 128
`define DCML_N_OFFSET 4
`define DCML_PAGE_BIT 12
`define DCML_LINE_WORDS 8
`define DCML_MAX_LOCKED 3
`endif

// *** include/dcml_pkg.sv ***
// types shared by the data cache maintenance and lockdown block
package dcml_pkg;
  typedef enum logic [2:0] {
    DCML_IDLE = 3'b000,
    DCML_LOOK = 3'b001,
    DCML_EVICT = 3'b011,
    DCML_FILL = 3'b010,
    DCML_EXT = 3'b110,
    DCML_MAINT = 3'b111
  } dcml_state_e;
  typedef enum logic [2:0] {
    DCML_OP_NONE = 3'h0,
    DCML_OP_FLUSH_ALL = 3'h1,
    DCML_OP_FLUSH_ONE = 3'h2,
    DCML_OP_CLEAN = 3'h3,
    DCML_OP_CLEAN_FLUSH = 3'h4
  } dcml_op_e;
endpackage

// *** include/dcml_tag_if.sv ***
// tag array access bundle between the controller and the tag store
`timescale 1ns/1ps
interface dcml_tag_if #(parameter int SET_W = 5, parameter int TAG_W = 22);
  logic [SET_W-1:0] set; // set index
  logic [1:0] way; // way being written
  logic wr; // write strobe
  logic [TAG_W-1:0] wtag; // tag to write
  logic wvalid; // valid to write
  logic [1:0] wdirty; // half-line dirty bits to write
  logic clr_all; // invalidate everything
  logic [4*TAG_W-1:0] rtag; // registered tags of all ways
  logic [3:0] rvalid; // registered valids
  logic [7:0] rdirty; // registered dirty bits
  modport ctrl (output set, way, wr, wtag, wvalid, wdirty, clr_all, input rtag, rvalid, rdirty);
  modport mem (input set, way, wr, wtag, wvalid, wdirty, clr_all, output rtag, rvalid, rdirty);
endinterface

// *** verilog/dcml_tag_mem.sv ***
// tag, valid and dirty store for four ways, read data registered
`timescale 1ns/1ps
module dcml_tag_mem #(
  parameter int SET_W = 5, // set index width
  parameter int TAG_W = 22 // tag width
) (
  input wire logic ref_clk, // core clock
  input wire logic nrst, // async reset, active low
  dcml_tag_if.mem t // tag access port
);
  logic [TAG_W-1:0] tag_r [4][2**SET_W];
  logic [3:0] valid_r [2**SET_W];
  logic [7:0] dirty_r [2**SET_W];

  // valids clear on reset so no stale line can hit
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int s = 0; s < 2**SET_W; s++) begin
        valid_r[s] <= 4'h0;
        dirty_r[s] <= 8'h00;
      end
    end else if (t.clr_all) begin
      for (int s = 0; s < 2**SET_W; s++) begin
        valid_r[s] <= 4'h0;
        dirty_r[s] <= 8'h00;
      end
    end else if (t.wr) begin
      valid_r[t.set][t.way] <= t.wvalid;
      dirty_r[t.set][2*t.way +: 2] <= t.wdirty;
    end
  end

  // tag storage needs no reset, valid guards it
  always_ff @(posedge ref_clk) begin
    if (t.wr) begin
      tag_r[t.way][t.set] <= t.wtag;
    end
  end

  // registered read of the addressed set
  genvar w;
  generate
    for (w = 0; w < 4; w++) begin : g_rd
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          t.rtag[w*TAG_W +: TAG_W] <= '0;
        end else begin
          t.rtag[w*TAG_W +: TAG_W] <= tag_r[w][t.set];
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      t.rvalid <= 4'h0;
      t.rdirty <= 8'h00;
    end else begin
      t.rvalid <= (t.clr_all) ? 4'h0 : valid_r[t.set];
      t.rdirty <= (t.clr_all) ? 8'h00 : dirty_r[t.set];
    end
  end
endmodule

// *** verilog/dcml_victim.sv ***
// victim way selection that skips locked segments
`timescale 1ns/1ps
module dcml_victim (
  input wire logic ref_clk, // core clock
  input wire logic nrst, // async reset, active low
  input wire logic step, // advance round robin
  input wire logic [1:0] lock_base, // first unlocked segment
  input wire logic lock_load, // lockdown load active
  input wire logic [1:0] lock_seg, // segment forced during lockdown load
  output logic [1:0] victim // chosen way
);
  logic [1:0] rr_r;

  // round robin over unlocked segments only
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rr_r <= 2'h0;
    end else if (step) begin
      rr_r <= (rr_r == 2'h3) ? lock_base : rr_r + 2'h1;
    end
  end

  // a stale pointer below the base is lifted to it
  always_comb begin
    if (lock_load) begin
      victim = lock_seg;
    end else if (rr_r < lock_base) begin
      victim = lock_base;
    end else begin
      victim = rr_r;
    end
  end
endmodule

// *** verilog/dcml_top.sv ***
// data cache policy, maintenance and lockdown controller
// Functional notes
// - write-back region: store hit updates cache only, marks half dirty
// - write-through region: store hit updates cache and external memory
// - enabled cache looks up all accesses; load hit data only if cachable
// - cachable load miss with protection on does eight-word linefill
// - noncachable load miss goes external, cache untouched
// - store hit updates the line only when cachable
// - store miss never allocates; buffering from attributes
// - multi-word transfers split at each 4KB boundary
// - flush all invalidates every line, no write-back
// - single flush invalidates addressed line, no write-back
// - clean writes dirty line out, line stays valid
// - clean and flush writes back dirty then invalidates
// - index operand: segment bits 31:30, index bits N:5, rest zero
// - N is 9 for 4KB up to 17 for 1MB
// - N equals log2(size/128) plus 4
// - lockdown per segment from zero, at most three locked
// - lockdown control: load bit 31, segment index 1:0
// - instruction lockdown has own load bit, only held and read back
// - evicting linefill writes back valid dirty halves first
// - disabled cache: lookup still runs but hits ignored, all noncachable, buffering still decoded
`timescale 1ns/1ps
`include "dcml_consts.svh"
module dcml_top #(
  parameter int CACHE_KB = 4 // cache size in KB, 4 to 1024
) (
  input wire logic ref_clk, // core clock 200 MHz
  input wire logic nrst, // async reset, active low
  input wire logic dc_enable, // data cache enable
  input wire logic prot_enable, // protection unit enable
  input wire logic req_valid, // core access request
  input wire logic req_write, // 1 store, 0 load
  input wire logic [31:0] req_addr, // access address
  input wire logic [3:0] req_words, // words in transfer, 1..8
  input wire logic cachable_data_attr, // region cachable
  input wire logic bufferable_data_attr, // region bufferable
  input wire logic op_valid, // maintenance op strobe
  input wire dcml_pkg::dcml_op_e op_kind, // maintenance op kind
  input wire logic op_by_index, // operand is index form
  input wire logic [31:0] op_operand, // maintenance operand
  input wire logic lock_wr, // write data lockdown control
  input wire logic [31:0] lock_wdata, // lockdown control data
  input wire logic ilock_wr, // write instruction lockdown control
  input wire logic [31:0] ilock_wdata, // instruction lockdown data
  input wire logic ext_done, // external transfer completed
  output logic busy, // controller busy
  output logic resp_valid, // access finished
  output logic resp_from_cache, // data came from cache
  output logic ext_req, // external request
  output logic ext_write, // external request is a write
  output logic ext_buffered, // write goes via write buffer
  output logic ext_linefill, // external request is a linefill
  output logic [31:0] ext_addr, // external address
  output logic [3:0] ext_words, // words in external request
  output logic [31:0] lock_rdata, // data lockdown control readback
  output logic [31:0] ilock_rdata, // instruction lockdown readback
  output logic [1:0] fill_way // way of the last linefill
);
  import dcml_pkg::*;

  // index top bit from cache size
  localparam int N_TOP = $clog2(CACHE_KB * 1024 / `DCML_SET_LINE_BYTES) + `DCML_N_OFFSET;
  localparam int SET_W = N_TOP - `DCML_LINE_LO + 1;
  localparam int TAG_W = 32 - `DCML_LINE_LO - SET_W;

  dcml_tag_if #(.SET_W(SET_W), .TAG_W(TAG_W)) tif ();

  dcml_state_e state_r, state_nxt;
  logic [31:0] lock_r, ilock_r;
  logic [31:0] addr_r;
  logic [3:0] left_r;
  logic wr_r, cach_r, buf_r;
  dcml_op_e op_r;
  logic idx_r;
  logic hit, vic_dirty, first_half_r, issue;
  logic [1:0] hway, victim, mway;
  logic [TAG_W-1:0] cur_tag;
  logic [3:0] chunk;

  // tag field of an address
  function automatic logic [TAG_W-1:0] tag_of(input logic [31:0] a);
    return a[31 -: TAG_W];
  endfunction

  // set index of an address
  function automatic logic [SET_W-1:0] set_of(input logic [31:0] a);
    return a[`DCML_LINE_LO +: SET_W];
  endfunction

  // locked segments are those below the data index, capped at three
  logic [1:0] lock_base;
  assign lock_base = lock_r[`DCML_LOCK_IDX_HI:`DCML_LOCK_IDX_LO];

  dcml_victim u_victim (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .step(state_r == DCML_FILL && ext_done),
    .lock_base(lock_base),
    .lock_load(lock_r[`DCML_LOCK_LOAD_BIT]),
    .lock_seg(lock_base),
    .victim(victim)
  );

  dcml_tag_mem #(.SET_W(SET_W), .TAG_W(TAG_W)) u_tags (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .t(tif.mem)
  );

  // hit detection on the registered tag read
  assign cur_tag = tag_of(addr_r);
  always_comb begin
    hit = 1'b0;
    hway = 2'h0;
    for (int w = 0; w < 4; w++) begin
      if (tif.rvalid[w] && tif.rtag[w*TAG_W +: TAG_W] == cur_tag) begin
        hit = 1'b1;
        hway = 2'(w);
      end
    end
  end

  // maintenance picks its way from the operand segment or an address match
  assign mway = idx_r ? addr_r[`DCML_SEG_HI:`DCML_SEG_LO] : hway;
  assign vic_dirty = |tif.rdirty[2*victim +: 2];
  // a new external request only on leaving lookup or after a completion
  assign issue = state_r == DCML_LOOK || ext_done;

  // words left before the next 4KB boundary
  always_comb begin
    logic [12:0] room;
    room = 13'h1000 - {1'b0, addr_r[11:0]};
    chunk = left_r;
    if ({9'h000, left_r, 2'b00} > room) begin
      chunk = 4'(room >> 2);
    end
  end

  // lockdown control registers
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lock_r <= `DCML_LOCK_RESET;
      ilock_r <= `DCML_LOCK_RESET;
    end else begin
      if (lock_wr) begin
        lock_r <= lock_wdata & 32'h8000_0003;
        if (lock_wdata[1:0] > 2'(`DCML_MAX_LOCKED) && !lock_wdata[31]) begin
          lock_r[1:0] <= 2'(`DCML_MAX_LOCKED);
        end
      end
      if (ilock_wr) begin
        ilock_r <= ilock_wdata & 32'h8000_0003;
      end
    end
  end

  // next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      DCML_IDLE: begin
        if (op_valid && op_kind == DCML_OP_FLUSH_ALL) begin
          state_nxt = DCML_IDLE;
        end else if (op_valid && op_kind != DCML_OP_NONE) begin
          state_nxt = DCML_LOOK;
        end else if (req_valid) begin
          state_nxt = DCML_LOOK;
        end
      end
      DCML_LOOK: begin
        if (op_r != DCML_OP_NONE) begin
          state_nxt = DCML_MAINT;
        end else if (!wr_r && !hit && cach_r) begin
          state_nxt = (tif.rvalid[victim] && vic_dirty) ? DCML_EVICT : DCML_FILL;
        end else if (!wr_r && hit && cach_r) begin
          state_nxt = DCML_IDLE;
        end else if (wr_r && hit && cach_r && buf_r) begin
          state_nxt = DCML_IDLE;
        end else begin
          state_nxt = DCML_EXT;
        end
      end
      DCML_EVICT: if (ext_done && !(tif.rdirty[2*victim] && tif.rdirty[2*victim+1]
                                      && first_half_r)) state_nxt = DCML_FILL;
      DCML_FILL: if (ext_done) state_nxt = DCML_IDLE;
      DCML_EXT: if (ext_done && left_r == chunk) state_nxt = DCML_IDLE;
      DCML_MAINT: begin
        if (!(hit || idx_r) || !(op_r == DCML_OP_CLEAN || op_r == DCML_OP_CLEAN_FLUSH)
            || !(|tif.rdirty[2*mway +: 2]) || (ext_done && !(first_half_r
            && tif.rdirty[2*mway] && tif.rdirty[2*mway+1]))) begin
          state_nxt = DCML_IDLE;
        end
      end
      default: state_nxt = DCML_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) state_r <= DCML_IDLE;
    else state_r <= state_nxt;
  end

  // capture the request; a disabled cache forces noncachable
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      addr_r <= 32'h0000_0000;
      left_r <= 4'h0;
      wr_r <= 1'b0;
      cach_r <= 1'b0;
      buf_r <= 1'b0;
      op_r <= DCML_OP_NONE;
      idx_r <= 1'b0;
      first_half_r <= 1'b1;
    end else begin
      if (state_r == DCML_IDLE && op_valid && op_kind != DCML_OP_FLUSH_ALL) begin
        op_r <= op_kind;
        idx_r <= op_by_index;
        // only segment and index bits matter in index form
        addr_r <= op_by_index ? (op_operand & {2'b11, 30'(((1 << (N_TOP + 1)) - 1)
                  & ~31)}) : op_operand;
        first_half_r <= 1'b1;
      end else if (state_r == DCML_IDLE && req_valid) begin
        op_r <= DCML_OP_NONE;
        addr_r <= req_addr;
        left_r <= req_words;
        wr_r <= req_write;
        cach_r <= cachable_data_attr & dc_enable;
        buf_r <= bufferable_data_attr;
        first_half_r <= 1'b1;
      end else if (state_r == DCML_EXT && ext_done) begin
        left_r <= left_r - chunk;
        addr_r <= addr_r + {26'h0, chunk, 2'b00};
      end else if ((state_r == DCML_EVICT || state_r == DCML_MAINT) && ext_done) begin
        first_half_r <= 1'b0;
      end else if (state_r == DCML_LOOK) begin
        // skip a clean first half so only dirty halves go out
        first_half_r <= op_r != DCML_OP_NONE ? !tif.rdirty[2*mway] == 1'b0
                        : !tif.rdirty[2*victim] == 1'b0;
      end
    end
  end

  // tag writes: fill, store hit dirty mark and maintenance
  always_comb begin
    tif.set = (state_r == DCML_IDLE) ? (op_valid ? set_of(op_operand) : set_of(req_addr))
              : set_of(addr_r);
    tif.way = mway;
    tif.wr = 1'b0;
    tif.wtag = cur_tag;
    tif.wvalid = 1'b1;
    tif.wdirty = tif.rdirty[2*mway +: 2];
    tif.clr_all = state_r == DCML_IDLE && op_valid && op_kind == DCML_OP_FLUSH_ALL;
    if (state_r == DCML_FILL && ext_done && prot_enable) begin
      tif.way = victim;
      tif.wr = 1'b1;
      tif.wdirty = 2'b00;
    end else if (state_r == DCML_LOOK && wr_r && hit && cach_r) begin
      tif.way = hway;
      tif.wr = 1'b1;
      tif.wdirty = tif.rdirty[2*hway +: 2];
      if (buf_r) tif.wdirty[addr_r[4]] = 1'b1;
    end else if (state_r == DCML_MAINT && (hit || idx_r) && state_nxt == DCML_IDLE) begin
      tif.wr = 1'b1;
      tif.wtag = tif.rtag[mway*TAG_W +: TAG_W];
      tif.wdirty = 2'b00;
      tif.wvalid = !(op_r == DCML_OP_FLUSH_ONE || op_r == DCML_OP_CLEAN_FLUSH);
      if (op_r == DCML_OP_CLEAN) tif.wvalid = tif.rvalid[mway];
    end
  end

  // external request, response and readback outputs
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      busy <= 1'b0;
      resp_valid <= 1'b0;
      resp_from_cache <= 1'b0;
      ext_req <= 1'b0;
      ext_write <= 1'b0;
      ext_buffered <= 1'b0;
      ext_linefill <= 1'b0;
      ext_addr <= 32'h0000_0000;
      ext_words <= 4'h0;
      lock_rdata <= `DCML_LOCK_RESET;
      ilock_rdata <= `DCML_LOCK_RESET;
      fill_way <= 2'h0;
    end else begin
      busy <= state_nxt != DCML_IDLE;
      lock_rdata <= lock_r;
      ilock_rdata <= ilock_r;
      resp_valid <= state_r != DCML_IDLE && state_nxt == DCML_IDLE && op_r == DCML_OP_NONE;
      resp_from_cache <= state_r == DCML_LOOK && !wr_r && hit && cach_r;
      ext_req <= 1'b0;
      ext_linefill <= 1'b0;
      if (issue && (state_nxt == DCML_EVICT || (state_nxt == DCML_MAINT && (hit || idx_r)
          && |tif.rdirty[2*mway +: 2]
          && (op_r == DCML_OP_CLEAN || op_r == DCML_OP_CLEAN_FLUSH)))) begin
        ext_req <= 1'b1;
        ext_write <= 1'b1;
        ext_buffered <= 1'b1;
        ext_words <= 4'h4;
        ext_addr <= {(state_nxt == DCML_EVICT ? tif.rtag[victim*TAG_W +: TAG_W]
                     : tif.rtag[mway*TAG_W +: TAG_W]), set_of(addr_r),
                     (state_r != DCML_LOOK // high half after a completion
                      || !tif.rdirty[2*(op_r == DCML_OP_NONE ? victim : mway)]), 4'h0};
      end else if (issue && state_nxt == DCML_FILL) begin
        ext_req <= 1'b1;
        ext_write <= 1'b0;
        ext_buffered <= 1'b0;
        ext_linefill <= 1'b1;
        ext_words <= 4'(`DCML_LINE_WORDS);
        ext_addr <= {addr_r[31:5], 5'h00};
        fill_way <= victim;
      end else if (issue && state_nxt == DCML_EXT) begin
        ext_req <= 1'b1;
        ext_write <= wr_r;
        ext_buffered <= wr_r && buf_r;
        // after a completion the remainder starts past the boundary and fits
        ext_addr <= (state_r == DCML_EXT) ? addr_r + {26'h0, chunk, 2'b00} : addr_r;
        ext_words <= (state_r == DCML_EXT) ? left_r - chunk : chunk;
      end
    end
  end
endmodule

// *** test/dcml_top_asserts.sv ***
// port-level checks for the data cache policy and lockdown controller
`timescale 1ns/1ps
module dcml_top_asserts (
  input wire logic ref_clk, // core clock
  input wire logic nrst, // async reset, active low
  input wire logic dc_enable, // cache enable
  input wire logic req_valid, // access request
  input wire logic req_write, // store when high
  input wire logic cachable_data_attr, // region cachable
  input wire logic op_valid, // maintenance strobe
  input wire dcml_pkg::dcml_op_e op_kind, // maintenance kind
  input wire logic lock_wr, // lockdown write
  input wire logic [31:0] lock_wdata, // lockdown data
  input wire logic busy, // controller busy
  input wire logic resp_from_cache, // data from cache
  input wire logic ext_req, // external request
  input wire logic ext_write, // external write
  input wire logic ext_linefill, // external linefill
  input wire logic [31:0] ext_addr, // external address
  input wire logic [3:0] ext_words, // external words
  input wire logic [31:0] lock_rdata, // lockdown readback
  input wire logic [1:0] fill_way // way of last fill
);
  import dcml_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic take_ld;
  logic take_st;
  // acceptance as seen at the ports; a maintenance op wins the cycle
  assign take_ld = req_valid && !busy && !op_valid && !req_write;
  assign take_st = req_valid && !busy && !op_valid && req_write;
  a_fill_shape: assert property (ext_req && ext_linefill |->
    ext_words == 4'h8 && !ext_write && ext_addr[4:0] == 5'h00)
    else $error("linefill not eight aligned words");
  a_split_page: assert property (ext_req && !ext_linefill |->
    ({1'b0, ext_addr[11:2]} + 11'(ext_words)) <= 11'h400)
    else $error("transfer crosses a 4KB boundary");
  a_nc_no_fill: assert property (take_ld && (!cachable_data_attr || !dc_enable) |->
    ##1 (!(ext_req && ext_linefill)) [*5])
    else $error("linefill for noncachable load");
  a_hit_needs_cd: assert property (resp_from_cache |->
    $past(take_ld && cachable_data_attr && dc_enable, 2))
    else $error("cache data without cachable enabled load");
  a_store_no_data: assert property (take_st |-> ##1 (!resp_from_cache) [*4])
    else $error("store returned cache data");
  a_flush_quiet: assert property (!busy && op_valid &&
    (op_kind == DCML_OP_FLUSH_ALL || op_kind == DCML_OP_FLUSH_ONE) |-> ##1 (!ext_req) [*4])
    else $error("flush wrote back data");
  a_flush_all_fast: assert property (!busy && op_valid && op_kind == DCML_OP_FLUSH_ALL
    |-> ##2 !busy)
    else $error("flush all not a single operation");
  a_lock_back: assert property (lock_wr |-> ##2 (lock_rdata[31] == $past(lock_wdata[31], 2)
    && lock_rdata[1:0] == $past(lock_wdata[1:0], 2)))
    else $error("lockdown control readback wrong");
  a_lock_fill_seg: assert property ($changed(fill_way) && lock_rdata[31] |->
    fill_way == lock_rdata[1:0])
    else $error("lockdown fill outside indexed segment");
  a_victim_free: assert property ($changed(fill_way) && !lock_rdata[31] |->
    fill_way >= lock_rdata[1:0])
    else $error("victim chosen in locked segment");
  // main scenarios reached
  c_hit: cover property (resp_from_cache);
  c_fill: cover property (ext_req && ext_linefill);
  c_half_wb: cover property (ext_req && ext_write && ext_words == 4'h4);
  c_lock_load: cover property (lock_wr && lock_wdata[31]);
endmodule
bind dcml_top dcml_top_asserts chk_u (.ref_clk, .nrst, .dc_enable, .req_valid, .req_write,
  .cachable_data_attr, .op_valid, .op_kind, .lock_wr, .lock_wdata, .busy, .resp_from_cache,
  .ext_req, .ext_write, .ext_linefill, .ext_addr, .ext_words, .lock_rdata, .fill_way);

// *** test/dcml_mem_model.sv ***
// external memory side: answers each request after a chosen delay
`timescale 1ns/1ps
module dcml_mem_model (
  input wire logic ref_clk, // core clock
  input wire logic nrst, // async reset, active low
  input wire logic ext_req, // request pulse
  input wire logic [3:0] delay, // wait cycles, 0 is prompt
  output logic ext_done // completion pulse
);
  logic [3:0] cnt_r;
  logic pend_r;
  // one transfer outstanding; done never appears without a request
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 4'h0;
      pend_r <= 1'b0;
      ext_done <= 1'b0;
    end else begin
      ext_done <= 1'b0;
      if (ext_req) begin
        pend_r <= 1'b1;
        cnt_r <= delay;
      end else if (pend_r && cnt_r == 4'h0) begin
        pend_r <= 1'b0;
        ext_done <= 1'b1;
      end else if (pend_r) begin
        cnt_r <= cnt_r - 4'h1;
      end
    end
  end
endmodule

// *** test/dcml_top_tb.sv ***
// self-checking bench for the data cache policy and lockdown controller
`timescale 1ns/1ps
module dcml_top_tb;
  import dcml_pkg::*;
  typedef struct packed {logic w; logic f; logic [31:0] a; logic [3:0] n;} dcml_xfer_s;
  logic ref_clk = 1'b0, nrst = 1'b0, dc_enable = 1'b0, prot_enable = 1'b0;
  logic req_valid = 1'b0, req_write = 1'b0, cachable_data_attr = 1'b0;
  logic bufferable_data_attr = 1'b0, op_valid = 1'b0, op_by_index = 1'b0;
  logic lock_wr = 1'b0, ilock_wr = 1'b0, ext_done;
  logic [3:0] req_words = 4'h1, dly = 4'h0, ext_words;
  logic [31:0] req_addr = 32'h0, op_operand = 32'h0, lock_wdata = 32'h0, ilock_wdata = 32'h0;
  dcml_op_e op_kind = DCML_OP_NONE;
  logic busy, resp_valid, resp_from_cache, ext_req, ext_write, ext_buffered, ext_linefill;
  logic [31:0] ext_addr, lock_rdata, ilock_rdata, a, c, l;
  logic [1:0] fill_way;
  logic [31:0] rng = 32'd17;
  int n_fail = 0, comparisons = 0, hits = 0;
  dcml_xfer_s q[$];
  dcml_top #(.CACHE_KB(4)) dut_u (.ref_clk, .nrst, .dc_enable, .prot_enable, .req_valid,
    .req_write, .req_addr, .req_words, .cachable_data_attr, .bufferable_data_attr, .op_valid,
    .op_kind, .op_by_index, .op_operand, .lock_wr, .lock_wdata, .ilock_wr, .ilock_wdata,
    .ext_done, .busy, .resp_valid, .resp_from_cache, .ext_req, .ext_write, .ext_buffered,
    .ext_linefill, .ext_addr, .ext_words, .lock_rdata, .ilock_rdata, .fill_way);
  dcml_mem_model mem_u (.ref_clk, .nrst, .ext_req, .delay(dly), .ext_done);
  // 200 MHz core clock
  always #2.5 ref_clk = ~ref_clk;
  // record every external request and every cache hit
  always @(posedge ref_clk) begin
    if (ext_req === 1'b1) q.push_back({ext_write, ext_linefill, ext_addr, ext_words});
    if (resp_from_cache === 1'b1) hits++;
  end
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  // words that fit before the next 4KB boundary
  function automatic logic [3:0] part1(input logic [31:0] ad, input logic [3:0] n);
    logic [12:0] room;
    room = (13'h1000 - {1'b0, ad[11:0]}) >> 2;
    return (13'(n) < room) ? n : room[3:0];
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // drop the strobe, wait for idle, then let the response pulses land
  task automatic finish_req();
    @(posedge ref_clk);
    req_valid <= 1'b0;
    op_valid <= 1'b0;
    for (int i = 0; i < 300; i++) begin
      @(posedge ref_clk);
      if (busy === 1'b0) break;
    end
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic acc(input logic w, input logic [31:0] ad, input logic [3:0] n, input logic cd,
      input logic bd);
    logic [31:0] r;
    r = xs();
    q.delete();
    hits = 0;
    @(posedge ref_clk);
    dly <= {1'b0, r[2:0]};
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= ad;
    req_words <= n;
    cachable_data_attr <= cd;
    bufferable_data_attr <= bd;
    finish_req();
  endtask
  task automatic mop(input dcml_op_e k, input logic ix, input logic [31:0] opnd);
    q.delete();
    @(posedge ref_clk);
    op_valid <= 1'b1;
    op_kind <= k;
    op_by_index <= ix;
    op_operand <= opnd;
    finish_req();
  endtask
  task automatic lockw(input logic [31:0] d, input logic [31:0] di);
    @(posedge ref_clk);
    lock_wr <= 1'b1;
    lock_wdata <= d;
    ilock_wr <= 1'b1;
    ilock_wdata <= di;
    @(posedge ref_clk);
    lock_wr <= 1'b0;
    ilock_wr <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk(lock_rdata & 32'h8000_0003, d & 32'h8000_0003);
    chk(ilock_rdata & 32'h8000_0003, di & 32'h8000_0003);
  endtask
  // watchdog sized well beyond the longest expected run
  initial begin
    repeat (30000) @(posedge ref_clk);
    n_fail++;
    complete_run();
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    chk(lock_rdata, 32'h0);
    chk(32'({busy, resp_valid, ext_req, fill_way}), 32'h0);
    dc_enable <= 1'b1;
    prot_enable <= 1'b1;
    for (int i = 0; i < 4; i++) lockw(xs(), xs());
    lockw(32'h0, 32'h0);
    a = xs() & 32'h0fff_efe0;
    acc(1'b0, a + 32'h4, 4'h1, 1'b1, 1'b1);
    chk(32'(q.size()), 1);
    chk({q[0].f, q[0].a}, {1'b1, a});
    acc(1'b0, a + 32'h4, 4'h1, 1'b1, 1'b1);
    chk(hits * 16 + q.size(), 32'h10);
    acc(1'b0, a + 32'h4, 4'h1, 1'b0, 1'b1);
    chk(32'({hits, q[0].f}), 32'h0);
    dc_enable <= 1'b0;
    acc(1'b0, a + 32'h4, 4'h1, 1'b1, 1'b1);
    chk(32'({hits, q[0].f}), 32'h0);
    dc_enable <= 1'b1;
    acc(1'b1, a + 32'h4, 4'h1, 1'b1, 1'b1);
    chk(32'(q.size()), 0);
    mop(DCML_OP_CLEAN, 1'b0, a);
    chk(32'(q.size()), 1);
    chk({q[0].w, q[0].a, q[0].n}, {1'b1, a, 4'h4});
    mop(DCML_OP_CLEAN, 1'b0, a);
    chk(32'(q.size()), 0);
    acc(1'b0, a, 4'h1, 1'b1, 1'b1);
    chk(32'(hits), 1);
    acc(1'b1, a + 32'h8, 4'h1, 1'b1, 1'b0);
    chk({q[0].w, q[0].a}, {1'b1, a + 32'h8});
    mop(DCML_OP_CLEAN, 1'b0, a);
    chk(32'(q.size()), 0);
    acc(1'b1, a ^ 32'h1000, 4'h1, 1'b1, 1'b1);
    chk(32'({q.size(), q[0].w}), 32'h3);
    acc(1'b0, a ^ 32'h1000, 4'h1, 1'b1, 1'b1);
    chk(32'({hits, q[q.size() - 1].f}), 32'h1);
    acc(1'b1, a, 4'h1, 1'b1, 1'b1);
    mop(DCML_OP_FLUSH_ONE, 1'b0, a);
    chk(32'(q.size()), 0);
    acc(1'b0, a, 4'h1, 1'b1, 1'b1);
    chk(32'({hits, q[q.size() - 1].f}), 32'h1);
    acc(1'b1, a + 32'h10, 4'h1, 1'b1, 1'b1);
    mop(DCML_OP_CLEAN_FLUSH, 1'b1, {fill_way, 20'h0, a[9:5], 5'h00});
    chk({q[0].w, q[0].a, q[0].n}, {1'b1, a + 32'h10, 4'h4});
    acc(1'b0, a, 4'h1, 1'b1, 1'b1);
    chk(32'(hits), 0);
    acc(1'b1, a, 4'h1, 1'b1, 1'b1);
    mop(DCML_OP_FLUSH_ALL, 1'b0, 32'h0);
    chk(32'(q.size()), 0);
    acc(1'b0, a, 4'h1, 1'b1, 1'b1);
    chk(32'(hits), 0);
    mop(DCML_OP_FLUSH_ALL, 1'b0, 32'h0);
    for (int w = 0; w < 2; w++) begin
      c = (a & 32'hffff_f000) | 32'h0000_0ff8;
      acc(w[0], c, 4'h4, 1'b0, 1'b1);
      chk(32'(q.size()), 2);
      chk({q[0].a, q[0].n}, {c, part1(c, 4'h4)});
      chk({q[1].a, q[1].n}, {c + 32'(part1(c, 4'h4)) * 4, 4'h4 - part1(c, 4'h4)});
    end
    l = a ^ 32'h0010_0000;
    lockw(32'h8000_0001, 32'h8000_0001);
    for (int k = 0; k < 2; k++) begin
      acc(1'b0, l + 32'(k) * 32 + 32'h1c, 4'h1, 1'b1, 1'b1);
      chk(32'(fill_way), 1);
    end
    lockw(32'h0000_0003, 32'h0000_0001);
    for (int k = 0; k < 4; k++) begin
      acc(1'b0, l + (32'h4000 << k), 4'h1, 1'b1, 1'b1);
      chk(32'(fill_way), 3);
    end
    acc(1'b1, l + 32'h2_0000, 4'h1, 1'b1, 1'b1);
    acc(1'b0, l + 32'h4_0000, 4'h1, 1'b1, 1'b1);
    chk({q[0].w, q[0].f, q[0].a, q[0].n}, {2'b10, l + 32'h2_0000, 4'h4});
    chk(32'(q.size()), 2);
    acc(1'b0, l, 4'h1, 1'b1, 1'b1);
    chk(32'(hits), 1);
    complete_run();
  end
endmodule
